/* File: include/dmsp_pkg.sv */
// shared constants for the dual mode serial port
package dmsp_pkg;
    // register byte offsets on the ahb-lite bus
    localparam logic [7:0] OFF_TXB = 8'h00;
    localparam logic [7:0] OFF_RXB = 8'h04;
    localparam logic [7:0] OFF_BRG = 8'h08;
    localparam logic [7:0] OFF_SMR = 8'h0C;
    localparam logic [7:0] OFF_CR0 = 8'h10;
    localparam logic [7:0] OFF_CR1 = 8'h14;
    // serial_mode_reg fields
    localparam int SMR_MODE = 0;
    localparam int SMR_CLOCK_SOURCE_DIR = 3;
    localparam int SMR_STOP2 = 4;
    localparam int SMR_EVEN = 5;
    localparam int SMR_PAREN = 6;
    // tx_rx_control0 fields
    localparam int CR0_SRC = 0;
    localparam int CR0_ODRAIN = 2;
    localparam int CR0_TX_SHIFT_EMPTY = 3;
    localparam int CR0_CLOCK_EDGE_SEL = 6;
    localparam int CR0_ORDER = 7;
    // tx_rx_control1 fields
    localparam int CR1_TXEN = 0;
    localparam int CR1_TXEMPTY = 1;
    localparam int CR1_RXEN = 2;
    localparam int CR1_RXDONE = 3;
    localparam int CR1_IRQSRC = 4;
    localparam int CR1_CONTRX = 5;
    // rx_buffer error fields
    localparam int RXB_OVR = 12;
    localparam int RXB_FER = 13;
    localparam int RXB_PER = 14;
    localparam int RXB_SUM = 15;
    // mode_select_field codes
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_SYNC = 3'h1;
    localparam logic [2:0] MODE_A7 = 3'h4;
    localparam logic [2:0] MODE_A8 = 3'h5;
    localparam logic [2:0] MODE_A9 = 3'h6;
    // reset values
    localparam logic [7:0] RST_BRG = 8'h00;
    localparam logic [6:0] RST_SMR = 7'h00;
    localparam logic [7:0] RST_CR0 = 8'h00;
    localparam logic [5:0] RST_CR1 = 6'h02;
    // timing counts
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [4:0] PRE_F8 = 5'h07;
    localparam logic [4:0] PRE_F32 = 5'h1F;
    localparam logic [3:0] SYNC_BITS = 4'h8;
    localparam logic [3:0] SYNC_OVR_IDX = 4'h6;
endpackage

/* File: core/dmsp_core.sv */
// Overview of operation
// RULE1 - continuous receive: buffer read clears tx empty
// RULE2 - software writes no dummy data then
// RULE3 - one start bit, seven/eight/nine data bits
// RULE4 - parity odd, even or none
// RULE5 - one or two stop bits
// RULE6 - internal rate: prescaled clock / 16(n+1)
// RULE7 - external rate: clock pin / 16(n+1)
// RULE8 - transmit needs enable and buffered data
// RULE9 - receive needs enable and start bit
// RULE10 - tx interrupt at load or at end
// RULE11 - rx interrupt when buffer is loaded
// RULE12 - overrun at bit before final stop
// RULE13 - framing error on missing stop bit
// RULE14 - parity error on wrong ones count
// RULE15 - summary flag is or of errors
// RULE16 - overrun leaves interrupt untouched, data undefined
// RULE17 - mode codes 100b/101b/110b pick length
// RULE18 - bit order honoured for eight bits only
// RULE19 - data in low seven/eight/nine bits
// RULE20 - output idles high or floats
// RULE21 - reading rx buffer clears errors, done; code keeps overrun until rx disable or mode off
// RULE22 - nine bit writes upper byte first
// RULE23 - sync polarity picks drive/sample edges
// RULE24 - sync clock: prescaled / 2(n+1)
// RULE25 - start low, stop high, centre sampling
// RULE26 - shift empty set while nothing shifting
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dmsp_core (
    input wire logic mclk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_out_oe,
    input wire logic transfer_clock_pin_i,
    output logic transfer_clock_pin_o,
    output logic transfer_clock_pin_oe,
    output logic tx_int_req,
    output logic rx_int_req
);
    // software visible state
    logic [8:0] tx_buffer_r;
    logic [8:0] rx_buffer_r;
    logic [7:0] baud_divisor_r;
    logic [6:0] serial_mode_r;
    logic [7:0] ctrl0_r;
    logic tx_enable_r, tx_buf_empty_r, rx_enable_r, rx_done_flag_r;
    logic tx_irq_source_sel_r, continuous_rx_sel_r;
    logic overrun_flag_r, framing_fault_flag_r, parity_fault_flag_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    // engines
    logic [4:0] presc_r;
    logic [7:0] brg_cnt_r;
    logic tick_r;
    logic [2:0] rx_sync_r, ck_sync_r;
    logic tx_busy_r, tx_sync_r;
    logic [12:0] tx_sh_r;
    logic [3:0] tx_left_r, tx_sub_r;
    logic out_r, out_oe_r, sclk_r, sclk_oe_r;
    logic rx_busy_r;
    logic [3:0] rx_sub_r, rx_idx_r;
    logic [8:0] rx_sh_r;
    logic rx_par_r, rx_fer_r;
    logic tx_int_r, rx_int_r;

    // mode decode
    wire [2:0] mode_select_field = serial_mode_r[dmsp_pkg::SMR_MODE +: 3];
    wire clock_source_dir = serial_mode_r[dmsp_pkg::SMR_CLOCK_SOURCE_DIR];
    wire stop_len_sel = serial_mode_r[dmsp_pkg::SMR_STOP2];
    wire odd_even_sel = serial_mode_r[dmsp_pkg::SMR_EVEN];
    wire parity_on_sel = serial_mode_r[dmsp_pkg::SMR_PAREN];
    wire [1:0] divider_source_sel = ctrl0_r[dmsp_pkg::CR0_SRC +: 2];
    wire open_drain_tx_sel = ctrl0_r[dmsp_pkg::CR0_ODRAIN];
    wire clock_edge_sel = ctrl0_r[dmsp_pkg::CR0_CLOCK_EDGE_SEL];
    wire bit_order_sel = ctrl0_r[dmsp_pkg::CR0_ORDER];
    wire async_on = (mode_select_field == dmsp_pkg::MODE_A7)
        || (mode_select_field == dmsp_pkg::MODE_A8)
        || (mode_select_field == dmsp_pkg::MODE_A9); // see RULE17
    wire sync_on = (mode_select_field == dmsp_pkg::MODE_SYNC);
    wire [3:0] char_len = (mode_select_field == dmsp_pkg::MODE_A7) ? 4'h7 :
        (mode_select_field == dmsp_pkg::MODE_A9) ? 4'h9 : 4'h8; // see RULE3
    wire msb_first = bit_order_sel && (char_len == 4'h8); // see RULE18
    wire [8:0] len_mask = (char_len == 4'h7) ? 9'h07F :
        (char_len == 4'h8) ? 9'h0FF : 9'h1FF; // see RULE19
    // frame length counts start, data, parity and stops
    wire [3:0] frame_bits = 4'h2 + char_len + {3'h0, parity_on_sel}
        + {3'h0, stop_len_sel}; // see RULE5

    function automatic logic [8:0] rev8(input logic [8:0] d);
        logic [8:0] r;
        r = d;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction

    // async frame, start bit at position 0, ones beyond the last data/parity bit
    function automatic logic [12:0] compose(input logic [8:0] d, input logic [3:0] len,
                                            input logic pen, input logic even);
        logic [12:0] f;
        logic p;
        f = 13'h1FFF;
        p = ~even;
        f[0] = 1'b0; // see RULE25
        for (int i = 0; i < 9; i++) begin
            if (i < int'(len)) begin
                f[i + 1] = d[i];
                p = p ^ d[i]; // parity over character bits only
            end
        end
        if (pen) begin
            f[len + 4'h1] = p; // see RULE4
        end
        return f;
    endfunction

    // bus decode
    wire acc = hsel && htrans[1] && hready;
    wire rd_acc = acc && !hwrite;
    wire [7:0] a_off = haddr[7:0];
    wire rxb_read = rd_acc && (a_off == dmsp_pkg::OFF_RXB);
    wire wr_txb = wr_pend_r && (wr_addr_r == dmsp_pkg::OFF_TXB);
    wire wr_brg = wr_pend_r && (wr_addr_r == dmsp_pkg::OFF_BRG);
    wire wr_smr = wr_pend_r && (wr_addr_r == dmsp_pkg::OFF_SMR);
    wire wr_cr0 = wr_pend_r && (wr_addr_r == dmsp_pkg::OFF_CR0);
    wire wr_cr1 = wr_pend_r && (wr_addr_r == dmsp_pkg::OFF_CR1);
    wire err_sum = overrun_flag_r || framing_fault_flag_r || parity_fault_flag_r; // see RULE15
    wire [31:0] rxb_word = {16'h0000, err_sum, parity_fault_flag_r, framing_fault_flag_r,
        overrun_flag_r, 3'h0, rx_buffer_r};
    wire [31:0] cr0_word = {24'h0, ctrl0_r[7:4], !tx_busy_r, ctrl0_r[2:0]}; // see RULE26
    wire [31:0] cr1_word = {26'h0, continuous_rx_sel_r, tx_irq_source_sel_r,
        rx_done_flag_r, rx_enable_r, tx_buf_empty_r, tx_enable_r};
    wire [31:0] rd_mux = (a_off == dmsp_pkg::OFF_TXB) ? {23'h0, tx_buffer_r} :
        (a_off == dmsp_pkg::OFF_RXB) ? rxb_word :
        (a_off == dmsp_pkg::OFF_BRG) ? {24'h0, baud_divisor_r} :
        (a_off == dmsp_pkg::OFF_SMR) ? {25'h0, serial_mode_r} :
        (a_off == dmsp_pkg::OFF_CR0) ? cr0_word :
        (a_off == dmsp_pkg::OFF_CR1) ? cr1_word : 32'h0000_0000;

    // bus slave: address phase latched, write data taken in data phase
    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= acc && hwrite;
            wr_addr_r <= a_off;
            if (rd_acc) begin
                hrdata_r <= rd_mux;
            end
        end
    end
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // configuration registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            baud_divisor_r <= dmsp_pkg::RST_BRG;
            serial_mode_r <= dmsp_pkg::RST_SMR;
            ctrl0_r <= dmsp_pkg::RST_CR0;
            {continuous_rx_sel_r, tx_irq_source_sel_r, rx_enable_r, tx_enable_r} <= 4'h0;
            tx_buffer_r <= 9'h000;
        end else begin
            if (wr_brg) baud_divisor_r <= hwdata[7:0];
            if (wr_smr) serial_mode_r <= hwdata[6:0];
            if (wr_cr0) ctrl0_r <= {hwdata[7:4], 1'b0, hwdata[2:0]};
            if (wr_cr1) begin
                tx_enable_r <= hwdata[dmsp_pkg::CR1_TXEN];
                rx_enable_r <= hwdata[dmsp_pkg::CR1_RXEN];
                tx_irq_source_sel_r <= hwdata[dmsp_pkg::CR1_IRQSRC];
                continuous_rx_sel_r <= hwdata[dmsp_pkg::CR1_CONTRX];
            end
            if (wr_txb) tx_buffer_r <= hwdata[8:0];
        end
    end

    // prescaler and baud divisor
    wire f8_en = (presc_r[2:0] == dmsp_pkg::PRE_F8[2:0]);
    wire f32_en = (presc_r == dmsp_pkg::PRE_F32);
    wire ext_rise = ck_sync_r[1] && !ck_sync_r[2];
    wire int_src = (divider_source_sel == 2'h0) ? 1'b1 :
        (divider_source_sel == 2'h1) ? f8_en : f32_en;
    wire src_en = (clock_source_dir && async_on) ? ext_rise : int_src; // see RULE7
    always_ff @(posedge mclk) begin
        if (srst) begin
            presc_r <= 5'h00;
            brg_cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end else begin
            presc_r <= presc_r + 5'h01;
            tick_r <= src_en && (brg_cnt_r == 8'h00); // see RULE6
            if (src_en) begin
                brg_cnt_r <= (brg_cnt_r == 8'h00) ? baud_divisor_r : brg_cnt_r - 8'h01;
            end
        end
    end

    // pin synchronisers
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_sync_r <= 3'h7;
            ck_sync_r <= 3'h7;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], serial_in_pin};
            ck_sync_r <= {ck_sync_r[1:0], transfer_clock_pin_i};
        end
    end
    wire rx_lvl = rx_sync_r[1];

    // sync transfer clock edges: lead edge drives, trail edge samples
    wire ck_idle = !clock_edge_sel; // see RULE23
    wire ext_chg = ck_sync_r[1] != ck_sync_r[2];
    wire s_lead = clock_source_dir ? (ext_chg && ck_sync_r[2] == ck_idle)
                                   : (tick_r && sclk_r == ck_idle);
    wire s_trail = clock_source_dir ? (ext_chg && ck_sync_r[1] == ck_idle)
                                    : (tick_r && sclk_r != ck_idle);

    // transmitter
    wire tx_go = !tx_busy_r && tx_enable_r && !tx_buf_empty_r && (async_on || sync_on); // see RULE8
    wire tx_step = tx_busy_r && (tx_sync_r ? s_trail : (tick_r && tx_sub_r == dmsp_pkg::OVS_LAST));
    wire tx_fin = tx_step && (tx_left_r == 4'h1);
    wire [8:0] tx_data = msb_first ? rev8(tx_buffer_r) : tx_buffer_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_busy_r <= 1'b0;
            tx_sync_r <= 1'b0;
            tx_sh_r <= 13'h1FFF;
            tx_left_r <= 4'h0;
            tx_sub_r <= 4'h0;
            out_r <= 1'b1;
        end else if (tx_go) begin
            tx_busy_r <= 1'b1;
            tx_sync_r <= sync_on;
            tx_sub_r <= 4'h0;
            if (sync_on) begin
                tx_sh_r <= {4'hF, (bit_order_sel ? rev8(tx_buffer_r) : tx_buffer_r)};
                tx_left_r <= dmsp_pkg::SYNC_BITS;
            end else begin
                tx_sh_r <= compose(tx_data, char_len, parity_on_sel, odd_even_sel);
                tx_left_r <= frame_bits;
                out_r <= 1'b0; // see RULE25
            end
        end else if (tx_busy_r) begin
            if (tick_r && !tx_sync_r) tx_sub_r <= tx_sub_r + 4'h1;
            if (tx_sync_r && s_lead) out_r <= tx_sh_r[0]; // see RULE23
            if (tx_step) begin
                tx_sh_r <= {1'b1, tx_sh_r[12:1]};
                tx_left_r <= tx_left_r - 4'h1;
                if (!tx_sync_r) out_r <= tx_fin ? 1'b1 : tx_sh_r[1];
                if (tx_fin) tx_busy_r <= 1'b0;
            end
        end else begin
            out_r <= 1'b1; // see RULE20
        end
    end

    // pin drivers: push-pull high when idle, open drain floats instead
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_oe_r <= 1'b0;
            sclk_r <= 1'b1;
            sclk_oe_r <= 1'b0;
        end else begin
            out_oe_r <= (async_on || sync_on) && (!open_drain_tx_sel || !out_r); // see RULE20
            sclk_oe_r <= sync_on && !clock_source_dir;
            if (!(tx_busy_r && tx_sync_r)) sclk_r <= ck_idle;
            else if (tick_r && !clock_source_dir) sclk_r <= !sclk_r; // see RULE24
        end
    end
    assign serial_out_pin = out_r;
    assign serial_out_oe = out_oe_r;
    assign transfer_clock_pin_o = sclk_r;
    assign transfer_clock_pin_oe = sclk_oe_r;

    // async receiver: start on falling edge, samples at sixteenth-bit centre
    wire rx_fall = !rx_sync_r[1] && rx_sync_r[2];
    wire rx_begin = !rx_busy_r && rx_enable_r && async_on && rx_fall; // see RULE9
    wire rx_samp = rx_busy_r && tick_r && (rx_sub_r == dmsp_pkg::OVS_MID); // see RULE25
    wire rx_bad_start = rx_samp && (rx_idx_r == 4'h0) && rx_lvl;
    wire rx_last = rx_samp && (rx_idx_r == frame_bits - 4'h1);
    wire rx_pre_last = rx_samp && (rx_idx_r == frame_bits - 4'h2);
    wire in_data = (rx_idx_r != 4'h0) && (rx_idx_r <= char_len);
    wire in_par = parity_on_sel && (rx_idx_r == char_len + 4'h1);
    wire in_stop = (rx_idx_r > char_len + {3'h0, parity_on_sel});
    wire sy_samp = tx_busy_r && tx_sync_r && s_trail;
    wire [3:0] sy_idx = dmsp_pkg::SYNC_BITS - tx_left_r;
    // completion events and error detection
    wire async_fin = rx_last;
    wire sync_fin = sy_samp && (tx_left_r == 4'h1) && rx_enable_r;
    wire rx_fin = async_fin || sync_fin;
    wire ovr_hit = rx_done_flag_r && (rx_pre_last
        || (sy_samp && rx_enable_r && sy_idx == dmsp_pkg::SYNC_OVR_IDX)); // see RULE12
    wire [8:0] rx_data = rx_sh_r & len_mask;
    wire par_bad = parity_on_sel && ((^rx_data) ^ rx_par_r ^ ~odd_even_sel); // see RULE14
    wire fer_now = rx_fer_r || (rx_last && !rx_lvl); // see RULE13
    wire store_ok = rx_fin && !overrun_flag_r && !ovr_hit; // see RULE16
    wire [8:0] st_data = (sync_fin ? bit_order_sel : msb_first) ? rev8(rx_sh_r) : rx_data;
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_busy_r <= 1'b0;
            rx_sub_r <= 4'h0;
            rx_idx_r <= 4'h0;
            rx_sh_r <= 9'h000;
            rx_par_r <= 1'b0;
            rx_fer_r <= 1'b0;
        end else if (rx_begin) begin
            {rx_busy_r, rx_sub_r, rx_idx_r, rx_fer_r} <= {1'b1, 4'h0, 4'h0, 1'b0};
        end else begin
            if (rx_busy_r && tick_r) rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_samp) rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_samp && in_data) rx_sh_r[rx_idx_r - 4'h1] <= rx_lvl;
            if (rx_samp && in_par) rx_par_r <= rx_lvl;
            if (rx_samp && in_stop && !rx_lvl) rx_fer_r <= 1'b1;
            if (rx_bad_start || rx_last || !async_on) rx_busy_r <= 1'b0;
            if (sy_samp) rx_sh_r[sy_idx] <= rx_lvl; // see RULE23
        end
    end

    // receive buffer, status flags; hardware set wins over a clearing read
    wire err_clr = (mode_select_field == dmsp_pkg::MODE_OFF) || !rx_enable_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_buffer_r <= 9'h000;
            {rx_done_flag_r, overrun_flag_r, framing_fault_flag_r, parity_fault_flag_r} <= 4'h0;
            rx_int_r <= 1'b0;
        end else begin
            rx_int_r <= store_ok; // see RULE11
            if (store_ok) rx_buffer_r <= st_data; // see RULE19
            if (store_ok) rx_done_flag_r <= 1'b1;
            else if (rxb_read) rx_done_flag_r <= 1'b0; // see RULE21
            if (ovr_hit) overrun_flag_r <= 1'b1;
            else if (err_clr) overrun_flag_r <= 1'b0;
            if (async_fin) framing_fault_flag_r <= fer_now;
            else if (rxb_read || err_clr) framing_fault_flag_r <= 1'b0; // see RULE21
            if (async_fin) parity_fault_flag_r <= par_bad;
            else if (rxb_read || err_clr) parity_fault_flag_r <= 1'b0;
        end
    end

    // transmit buffer empty flag and transmit interrupt
    wire cont_clr = rxb_read && continuous_rx_sel_r && sync_on; // see RULE1
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx_buf_empty_r <= dmsp_pkg::RST_CR1[dmsp_pkg::CR1_TXEMPTY];
            tx_int_r <= 1'b0;
        end else begin
            if (wr_txb || cont_clr) tx_buf_empty_r <= 1'b0;
            else if (tx_go) tx_buf_empty_r <= 1'b1;
            tx_int_r <= tx_irq_source_sel_r ? tx_fin : tx_go; // see RULE10
        end
    end
    assign tx_int_req = tx_int_r;
    assign rx_int_req = rx_int_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    tx_start_cond_a: assert property ($rose(tx_busy_r) |-> $past(tx_enable_r && !tx_buf_empty_r)) // see RULE8
        else $error("transmit started without enable or data");
    tx_irq_src_a: assert property (tx_int_r |-> $past(tx_irq_source_sel_r ? tx_fin : tx_go)) // see RULE10
        else $error("transmit interrupt at wrong point");
    rx_irq_store_a: assert property (store_ok |=> rx_int_r && rx_done_flag_r) // see RULE11
        else $error("receive completion not flagged");
    ovr_no_irq_a: assert property (rx_fin && (overrun_flag_r || ovr_hit) |=> !rx_int_r) // see RULE16
        else $error("overrun raised receive interrupt");
    sum_flag_a: assert property (rxb_read |=> hrdata_r[dmsp_pkg::RXB_SUM] == $past(err_sum)) // see RULE15
        else $error("summary flag mismatch");
    rx_read_clr_a: assert property (rxb_read && !store_ok |=> !rx_done_flag_r) // see RULE21
        else $error("buffer read did not clear done flag");
    cont_rx_a: assert property (cont_clr |=> !tx_buf_empty_r ##1 tx_busy_r || !tx_enable_r) // see RULE1
        else $error("continuous receive did not restart");
    start_low_a: assert property ($rose(tx_busy_r) && async_on |-> !out_r) // see RULE25
        else $error("start bit not low");
    idle_high_a: assert property (!tx_busy_r && $past(!tx_busy_r, 2) |-> out_r) // see RULE20
        else $error("idle line not high");
    shift_empty_a: assert property (tx_go |=> !cr0_word[dmsp_pkg::CR0_TX_SHIFT_EMPTY] [*2]) // see RULE26
        else $error("shift empty set while shifting");
    cov_async_tx_c: cover property (tx_go && async_on ##[1:1000] tx_fin);
    cov_async_rx_c: cover property (async_fin && store_ok);
    cov_overrun_c: cover property (ovr_hit);
    cov_sync_c: cover property (sync_fin);
endmodule // dmsp_core
`default_nettype wire

/* File: verification/dmsp_remote_node.sv */
`timescale 1ns/10ps
`default_nettype none
module dmsp_remote_node (
    input wire logic mclk,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe,
    output logic serial_in_pin
);
    int bit_cyc = 16;
    time start_at = 0;
    wire logic line;
    // a released driver leaves the pull-up in charge
    assign line = serial_out_oe ? serial_out_pin : 1'b1;
    initial begin
        serial_in_pin = 1'b1;
    end
    // frame onto the device input, stop level chosen by caller
    task automatic send(input logic [8:0] d, input int nb, input int pen, input logic p,
                        input logic stop);
        int i;
        @(posedge mclk);
        serial_in_pin <= 1'b0;
        repeat (bit_cyc) @(posedge mclk);
        for (i = 0; i < nb; i++) begin
            serial_in_pin <= d[i];
            repeat (bit_cyc) @(posedge mclk);
        end
        if (pen != 0) begin
            serial_in_pin <= p;
            repeat (bit_cyc) @(posedge mclk);
        end
        serial_in_pin <= stop;
        repeat (bit_cyc) @(posedge mclk);
        serial_in_pin <= 1'b1;
        repeat (bit_cyc) @(posedge mclk);
    endtask
    // centre sampling of one device frame
    task automatic recv(input int nb, input int pen, input int nst, output logic [8:0] d,
                        output logic p, output logic ok);
        int i;
        d = 9'h000;
        p = 1'b0;
        for (i = 0; i < 20000 && line !== 1'b0; i++) @(posedge mclk);
        start_at = $time;
        repeat (bit_cyc / 2) @(posedge mclk);
        ok = ~line;
        for (i = 0; i < nb; i++) begin
            repeat (bit_cyc) @(posedge mclk);
            d[i] = line;
        end
        if (pen != 0) begin
            repeat (bit_cyc) @(posedge mclk);
            p = line;
        end
        for (i = 0; i < nst; i++) begin
            repeat (bit_cyc) @(posedge mclk);
            ok = ok & line;
        end
    endtask
endmodule // dmsp_remote_node
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic so, soe, cko, ckoe, txi, rxi, si;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    int fails = 0, samples_checked = 0, cyc = 0, txn = 0, rxn = 0, n0;
    time tx_at = 0;
    logic [1:0] ckd = 2'h0;
    // external baud source: one rising edge every four clocks
    always @(posedge mclk) ckd <= ckd + 2'h1;
    initial begin
        forever #2 mclk = ~mclk;
    end
    dmsp_core dut (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .serial_in_pin(si),
        .serial_out_pin(so), .serial_out_oe(soe), .transfer_clock_pin_i(ckd[1]),
        .transfer_clock_pin_o(cko), .transfer_clock_pin_oe(ckoe), .tx_int_req(txi),
        .rx_int_req(rxi));
    dmsp_remote_node node (.mclk(mclk), .serial_out_pin(so), .serial_out_oe(soe),
        .serial_in_pin(si));
    // event counters and hang guard
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (txi === 1'b1) begin
            txn = txn + 1;
            tx_at = $time;
        end
        if (rxi === 1'b1) rxn = rxn + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one single ahb-lite transfer, read data left in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    // send one character from the device and judge it on the wire
    task automatic tx_one(input logic [6:0] smr, input logic src, input logic [8:0] d,
                          input int nb, input int pen, input int nst, input logic ev);
        logic [8:0] got, m;
        logic p, ok;
        m = 9'((1 << nb) - 1);
        bus(1'b1, dmsp_pkg::OFF_SMR, {25'h000_0000, smr});
        repeat (2) @(posedge mclk);
        check({30'h0000_0000, so, soe}, 32'h0000_0003, "idle line");
        bus(1'b1, dmsp_pkg::OFF_CR1, {27'h000_0000, src, 4'h5});
        n0 = txn;
        bus(1'b1, dmsp_pkg::OFF_TXB, {23'h00_0000, d});
        node.recv(nb, pen, nst, got, p, ok);
        repeat (node.bit_cyc * 2) @(posedge mclk);
        check(got, d & m, "tx data");
        if (pen != 0) check(p, ev ? ^(d & m) : ~^(d & m), "tx parity");
        check(ok, 1, "tx start stop");
        check(txn - n0, 1, "tx irq count");
        check(src ? tx_at > node.start_at + (nb + pen + 1) * node.bit_cyc * 4
                  : tx_at <= node.start_at + 8, 1, "tx irq time");
    endtask
    task automatic rx_one(input logic [8:0] d, input logic bad_p, input logic stop,
                          input logic [31:0] exp);
        n0 = rxn;
        node.send(d, 8, 1, ~^d ^ bad_p ^ 1'b1, stop);
        bus(1'b0, dmsp_pkg::OFF_RXB, 32'h0000_0000);
        check(rd, exp, "rx word");
        check(rxn - n0, 1, "rx irq");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, dmsp_pkg::OFF_CR1, 32'h0000_0000);
        check(rd, {26'h000_0000, dmsp_pkg::RST_CR1}, "cr1 reset");
        bus(1'b0, dmsp_pkg::OFF_CR0, 32'h0000_0000);
        check(rd, 32'h0000_0008, "cr0 reset");
        bus(1'b0, 8'hFC, 32'h0000_0000);
        check(rd, 32'h0000_0000, "unmapped");
        bus(1'b1, dmsp_pkg::OFF_BRG, 32'h0000_0000);
        tx_one(7'h54, 1'b0, 9'h1A5, 7, 1, 2, 1'b0);
        tx_one(7'h05, 1'b1, 9'h0C3, 8, 0, 1, 1'b0);
        tx_one(7'h66, 1'b0, 9'h13C, 9, 1, 1, 1'b1);
        // slower rate: f/8 source and divisor one
        bus(1'b1, dmsp_pkg::OFF_BRG, 32'h0000_0001);
        bus(1'b1, dmsp_pkg::OFF_CR0, 32'h0000_0001);
        node.bit_cyc = 256;
        tx_one(7'h05, 1'b0, 9'h05A, 8, 0, 1, 1'b0);
        bus(1'b1, dmsp_pkg::OFF_BRG, 32'h0000_0000);
        bus(1'b1, dmsp_pkg::OFF_CR0, 32'h0000_0000);
        node.bit_cyc = 64;
        tx_one(7'h0D, 1'b0, 9'h0A7, 8, 0, 1, 1'b0);
        node.bit_cyc = 16;
        bus(1'b1, dmsp_pkg::OFF_SMR, 32'h0000_0065);
        rx_one(9'h05A, 1'b0, 1'b1, 32'h0000_005A);
        bus(1'b0, dmsp_pkg::OFF_CR1, 32'h0000_0000);
        check(rd & 32'h0000_0008, 32'h0000_0000, "rx done cleared");
        rx_one(9'h05A, 1'b1, 1'b1, 32'h0000_C05A);
        rx_one(9'h0A5, 1'b0, 1'b0, 32'h0000_A0A5);
        n0 = rxn;
        node.send(9'h011, 8, 1, 1'b0, 1'b1);
        node.send(9'h022, 8, 1, 1'b0, 1'b1);
        bus(1'b0, dmsp_pkg::OFF_RXB, 32'h0000_0000);
        check(rd & 32'h0000_F000, 32'h0000_9000, "overrun");
        check(rxn - n0, 1, "overrun irq");
        bus(1'b1, dmsp_pkg::OFF_CR1, 32'h0000_0001);
        n0 = rxn;
        node.send(9'h033, 8, 1, 1'b0, 1'b1);
        check(rxn - n0, 0, "rx disabled");
        bus(1'b1, dmsp_pkg::OFF_SMR, 32'h0000_0001);
        bus(1'b1, dmsp_pkg::OFF_CR1, 32'h0000_0024);
        bus(1'b0, dmsp_pkg::OFF_RXB, 32'h0000_0000);
        bus(1'b0, dmsp_pkg::OFF_CR1, 32'h0000_0000);
        check(rd, 32'h0000_0024, "continuous rx");
        check({29'h0000_0000, hresp, cko, ckoe}, 32'h0000_0003, "okay, sync clock idle");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
